// file: srcr_host_pin.sv
/* Host model of the hibernate clocking pin: a start pulse makes it change
   the pin level a set number of times, one change every two clocks.
   Assumes the bank counts each level change of the pin as one toggle. */
`timescale 1ns/10ps
module srcr_host_pin #(
  parameter int TOGGLES = 2 // Level changes per transition.
)(
  // Clock and request.
  input  wire logic clk,
  input  wire logic start,
  // Pin towards the bank.
  output logic      pin
);
  int cnt = 0; // Half-steps left in the burst.

  initial pin = 1'b0;

  // Two clocks per level keeps each toggle wide for an edge detector.
  always @(posedge clk) begin
    if (start && cnt == 0) begin
      cnt <= 2 * TOGGLES;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
      if (cnt % 2 == 0) begin
        pin <= ~pin;
      end
    end
  end
endmodule // srcr_host_pin

// file: srcr_pacer.sv
/*
  Measurement pacer for the sparse radar register bank.
  Assumes rate in millihertz and the policy code of the repeat policy register.
*/
`timescale 1ns/10ps
module srcr_pacer
  import srcr_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // Settings and request.
  input  wire logic [31:0] policy,
  input  wire logic [31:0] rate,
  input  wire logic        want,
  // Measurement start pulse.
  output logic             go
);

  // Accumulator of millihertz counts, one PACE_LIMIT per measurement.
  typedef struct packed {
    logic [39:0] acc;
    logic        go;
  } srcr_pace_t;

  srcr_pace_t s_reg;
  srcr_pace_t s_next;
  logic [39:0] sum;

  // Next-state logic: free pacing or software cap.
  always_comb begin
    s_next    = s_reg;
    s_next.go = 1'b0;
    sum       = s_reg.acc + {8'h00, rate};
    if (policy == POL_SENSOR) begin
      // The sensor paces itself, keeping the remainder for precision.
      if (sum >= PACE_LIMIT) begin
        s_next.acc = sum - PACE_LIMIT;
        s_next.go  = 1'b1;
      end else begin
        s_next.acc = sum;
      end
    end else if (policy == POL_SOFT) begin
      // Credit saturates at one period, so a late request goes at once.
      s_next.acc = (sum > PACE_LIMIT) ? PACE_LIMIT : sum;
      if (want && (rate == RST_ZERO || s_reg.acc >= PACE_LIMIT)) begin
        s_next.go  = 1'b1;
        s_next.acc = 40'h00_0000_0000;
      end
    end else begin
      s_next.acc = 40'h00_0000_0000;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign go = s_reg.go;

  // Software cap with zero rate never holds a request back.
  a_uncapped_go: assert property (@(posedge clk) disable iff (!reset_n)
    ce && policy == POL_SOFT && rate == RST_ZERO && want |=> go)
    else $error("uncapped request not granted");
  // Self pacing can never start two measurements back to back.
  a_sensor_gap: assert property (@(posedge clk) disable iff (!reset_n)
    go && ce && policy == POL_SENSOR |=> !go)
    else $error("self paced starts too close");

endmodule // srcr_pacer

// file: srcr_pkg.sv
/*
  Constants for the sparse radar configuration register bank: register
  offsets, reset values, field codes and pacing timing.
  Assumes a single 100 MHz clock and an 8-bit register address space.
*/
package srcr_pkg;

  // Register offsets, one per register, at the printed addresses.
  localparam logic [7:0] OFF_RANGE_BEGIN = 8'h20;
  localparam logic [7:0] OFF_RANGE_SPAN  = 8'h21;
  localparam logic [7:0] OFF_POLICY      = 8'h22;
  localparam logic [7:0] OFF_RATE        = 8'h23;
  localparam logic [7:0] OFF_GAIN        = 8'h24;
  localparam logic [7:0] OFF_POWER       = 8'h25;
  localparam logic [7:0] OFF_TX_OFF      = 8'h26;
  localparam logic [7:0] OFF_PROFILE     = 8'h28;
  localparam logic [7:0] OFF_DECIM       = 8'h29;
  localparam logic [7:0] OFF_AVG         = 8'h30;
  localparam logic [7:0] OFF_ATTEN       = 8'h32;
  localparam logic [7:0] OFF_ASYNC       = 8'h33;
  localparam logic [7:0] OFF_FRAME_SW    = 8'h40;
  localparam logic [7:0] OFF_REQ_RATE    = 8'h41;
  localparam logic [7:0] OFF_SCHEME      = 8'h42;
  localparam logic [7:0] OFF_SW_BEGIN    = 8'h81;
  localparam logic [7:0] OFF_SW_SPAN     = 8'h82;
  localparam logic [7:0] OFF_VEC_LEN     = 8'h83;
  localparam logic [7:0] OFF_ACT_RATE    = 8'h84;
  localparam logic [7:0] OFF_SPACING     = 8'h85;
  localparam logic [7:0] OFF_SATURATED   = 8'hA0;
  localparam logic [7:0] OFF_DATA_LOSS   = 8'hA1;
  localparam logic [7:0] OFF_LINK_FAULT  = 8'hA4;

  // Field codes.
  localparam logic [31:0] POL_SENSOR  = 32'h0000_0001;
  localparam logic [31:0] POL_SOFT    = 32'h0000_0002;
  localparam logic [31:0] PWR_OFF     = 32'h0000_0000;
  localparam logic [31:0] PWR_ACTIVE  = 32'h0000_0003;
  localparam logic [31:0] PWR_HIB     = 32'h0000_0004;
  localparam logic [31:0] PROF_MIN    = 32'h0000_0001;
  localparam logic [31:0] PROF_MAX    = 32'h0000_0005;
  localparam logic [31:0] SCHEME_LAST = 32'h0000_0001;
  localparam logic [31:0] GAIN_MAX    = 32'h0000_03E8;

  // Reset values.
  localparam logic [31:0] RST_ZERO    = 32'h0000_0000;
  localparam logic [31:0] RST_POLICY  = 32'h0000_0002;
  localparam logic [31:0] RST_GAIN    = 32'h0000_01F4;
  localparam logic [31:0] RST_POWER   = 32'h0000_0003;
  localparam logic [31:0] RST_PROFILE = 32'h0000_0001;
  localparam logic [31:0] RST_ONE     = 32'h0000_0001;

  // Pacing: rates count in millihertz, so one hertz is a thousand counts.
  localparam longint CLK_HZ     = 100_000_000;
  localparam longint MHZ_PER_HZ = 1000;
  localparam logic [39:0] PACE_LIMIT = 40'(CLK_HZ * MHZ_PER_HZ);

  // Default count of pin toggles that moves in or out of hibernate.
  localparam int HIB_TOGGLES_DEF = 8;

  // Oscillator phase.
  typedef enum logic [0:0] {
    SRCR_OSC_RUN = 1'b0,
    SRCR_OSC_HIB = 1'b1
  } srcr_osc_t;

endpackage

// file: srcr_regs.sv
/*
  Register bank of the sparse measurement service: configuration in, sweep
  metadata and error flags out, plus pacing and hibernate control.
  Assumes a transport that presents one-cycle read and write strobes with
  an 8-bit address, and a measurement engine that pulses its events.
*/
`timescale 1ns/10ps
module srcr_regs
  import srcr_pkg::*;
#(
  parameter int HIB_TOGGLES = HIB_TOGGLES_DEF // Pin toggles per transition.
)(
  // Clock, reset and enable.
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  // Register access from the serial transport.
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  output logic             reg_rvalid,
  // Measurement engine events and metadata.
  input  wire logic        svc_create,
  input  wire logic        data_ready,
  input  wire logic [31:0] meta_begin_mm,
  input  wire logic [31:0] meta_span_mm,
  input  wire logic [31:0] meta_vec_len,
  input  wire logic [31:0] meta_sweep_rate,
  input  wire logic [31:0] meta_spacing_um,
  input  wire logic        sat_event,
  input  wire logic        loss_event,
  input  wire logic        link_err_event,
  input  wire logic        meas_want,
  // Hibernate clocking pin from the host.
  input  wire logic        hib_pin,
  // Configuration towards the sensor.
  output logic [31:0]      cfg_range_begin_mm,
  output logic [31:0]      cfg_range_span_mm,
  output logic [31:0]      cfg_gain,
  output logic [2:0]       cfg_power_state,
  output logic             tx_enable,
  output logic [2:0]       cfg_profile,
  output logic [31:0]      cfg_decimation,
  output logic [31:0]      cfg_avg_count,
  output logic             cfg_atten_max,
  output logic             cfg_async,
  output logic [31:0]      cfg_frame_sweeps,
  output logic [31:0]      cfg_sweep_rate_mhz,
  output logic             sweep_rate_max,
  output logic             cfg_scheme,
  output logic             meas_go,
  output logic             osc_running
);

  // State of the bank in one record; the pacer keeps its own.
  typedef struct packed {
    logic [31:0] rb;     // Range begin, mm.
    logic [31:0] rs;     // Range span, mm.
    logic [31:0] pol;    // Repeat policy.
    logic [31:0] rate;   // Refresh rate, mHz.
    logic [31:0] gain;   // Receiver gain.
    logic [31:0] pwr;    // Power state code.
    logic [31:0] txo;    // Transmitter off.
    logic [31:0] prof;   // Profile code.
    logic [31:0] dec;    // Decimation factor.
    logic [31:0] avg;    // Averaging count.
    logic [31:0] att;    // Leakage attenuation maximum.
    logic [31:0] asy;    // Asynchronous mode.
    logic [31:0] fsc;    // Sweeps per frame.
    logic [31:0] srq;    // Requested sweep rate, mHz.
    logic [31:0] sch;    // Sampling scheme.
    logic [31:0] mb;     // Sweep begin, mm.
    logic [31:0] ms;     // Sweep span, mm.
    logic [31:0] ml;     // Output vector length.
    logic [31:0] mr;     // Actual sweep rate, mHz.
    logic [31:0] mp;     // Point spacing, um.
    logic        sat;    // Saturation flag.
    logic        loss;   // Data loss flag.
    logic        fault;  // Link fault flag.
    srcr_osc_t   osc;    // Oscillator phase.
    logic [7:0]  tcnt;   // Hibernate pin toggle count.
    logic        pin_q;  // Previous hibernate pin level.
    logic [31:0] rdata;  // Read answer.
    logic        rvalid; // Read answer valid.
    logic        tx_en;  // Transmitter enable.
    logic        smax;   // Maximum sweep rate requested.
  } srcr_state_t;

  srcr_state_t s_reg;
  srcr_state_t s_next;
  logic        wr_go;    // Write strobe qualified by the enable.
  logic        rd_go;    // Read strobe qualified by the enable.
  logic        pace_go;  // Measurement start from the pacer.
  logic        toggled;  // Hibernate pin changed level.

  // Pacer applies the repeat policy to the refresh rate.
  srcr_pacer u_pacer (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .policy  (s_reg.pol),
    .rate    (s_reg.rate),
    .want    (meas_want),
    .go      (pace_go)
  );

  // Next-state logic: writes, reads, metadata, flags and hibernate.
  always_comb begin
    s_next        = s_reg;
    wr_go         = ce && reg_wr;
    rd_go         = ce && reg_rd;
    toggled       = hib_pin != s_reg.pin_q;
    s_next.pin_q  = hib_pin;
    s_next.rvalid = rd_go;

    // Register writes; read-only and unmapped addresses are ignored.
    if (wr_go) begin
      case (reg_addr)
        OFF_RANGE_BEGIN: s_next.rb = reg_wdata;
        OFF_RANGE_SPAN:  s_next.rs = reg_wdata;
        OFF_POLICY: begin
          // Only the two documented policies are accepted.
          if (reg_wdata == POL_SENSOR || reg_wdata == POL_SOFT) begin
            s_next.pol = reg_wdata;
          end
        end
        OFF_RATE: s_next.rate = reg_wdata;
        OFF_GAIN: begin
          // Values above the top of the scale are refused.
          if (reg_wdata <= GAIN_MAX) begin
            s_next.gain = reg_wdata;
          end
        end
        OFF_POWER: begin
          // Codes off through active, plus hibernate.
          if (reg_wdata <= PWR_HIB) begin
            s_next.pwr = reg_wdata;
          end
        end
        OFF_TX_OFF: s_next.txo = reg_wdata;
        OFF_PROFILE: begin
          // Codes between the ends select the graded trade-offs.
          if (reg_wdata >= PROF_MIN && reg_wdata <= PROF_MAX) begin
            s_next.prof = reg_wdata;
          end
        end
        OFF_DECIM:    s_next.dec = reg_wdata;
        OFF_AVG:      s_next.avg = reg_wdata;
        OFF_ATTEN:    s_next.att = reg_wdata;
        OFF_ASYNC:    s_next.asy = reg_wdata;
        OFF_FRAME_SW: s_next.fsc = reg_wdata;
        OFF_REQ_RATE: s_next.srq = reg_wdata;
        OFF_SCHEME: begin
          // Only schemes A and B exist.
          if (reg_wdata <= SCHEME_LAST) begin
            s_next.sch = reg_wdata;
          end
        end
        default: begin
          // Nothing to store.
        end
      endcase
    end

    // Derived controls follow the values just stored.
    s_next.tx_en = !s_next.txo[0];
    s_next.smax  = s_next.srq == RST_ZERO;

    // Metadata is refreshed on service creation or new data.
    if (ce && (svc_create || data_ready)) begin
      s_next.mb = meta_begin_mm;
      s_next.ms = meta_span_mm;
      s_next.ml = meta_vec_len;
      s_next.mr = meta_sweep_rate;
      s_next.mp = meta_spacing_um;
    end

    // Flags: a read clears saturation and loss, a new service the fault.
    // An event in the clearing cycle wins so that none is lost.
    if (rd_go && reg_addr == OFF_SATURATED) begin
      s_next.sat = 1'b0;
    end
    if (rd_go && reg_addr == OFF_DATA_LOSS) begin
      s_next.loss = 1'b0;
    end
    if (ce && svc_create) begin
      s_next.fault = 1'b0;
    end
    if (ce && sat_event) begin
      s_next.sat = 1'b1;
    end
    if (ce && loss_event) begin
      s_next.loss = 1'b1;
    end
    if (ce && link_err_event) begin
      s_next.fault = 1'b1;
    end

    // Hibernate: the host clocks the sensor by toggling a pin.
    // Toggles only count while hibernate is requested or in force.
    if (ce && toggled && (s_reg.pwr == PWR_HIB || s_reg.osc == SRCR_OSC_HIB)) begin
      if (s_reg.tcnt == 8'(HIB_TOGGLES - 1)) begin
        s_next.tcnt = 8'h00;
        case (s_reg.osc)
          SRCR_OSC_RUN: s_next.osc = SRCR_OSC_HIB;
          SRCR_OSC_HIB: s_next.osc = SRCR_OSC_RUN;
          default:      s_next.osc = SRCR_OSC_RUN;
        endcase
      end else begin
        s_next.tcnt = s_reg.tcnt + 8'h01;
      end
    end

    // Read multiplexer; unmapped addresses read as zero.
    if (rd_go) begin
      case (reg_addr)
        OFF_RANGE_BEGIN: s_next.rdata = s_reg.rb;
        OFF_RANGE_SPAN:  s_next.rdata = s_reg.rs;
        OFF_POLICY:      s_next.rdata = s_reg.pol;
        OFF_RATE:        s_next.rdata = s_reg.rate;
        OFF_GAIN:        s_next.rdata = s_reg.gain;
        OFF_POWER:       s_next.rdata = s_reg.pwr;
        OFF_TX_OFF:      s_next.rdata = s_reg.txo;
        OFF_PROFILE:     s_next.rdata = s_reg.prof;
        OFF_DECIM:       s_next.rdata = s_reg.dec;
        OFF_AVG:         s_next.rdata = s_reg.avg;
        OFF_ATTEN:       s_next.rdata = s_reg.att;
        OFF_ASYNC:       s_next.rdata = s_reg.asy;
        OFF_FRAME_SW:    s_next.rdata = s_reg.fsc;
        OFF_REQ_RATE:    s_next.rdata = s_reg.srq;
        OFF_SCHEME:      s_next.rdata = s_reg.sch;
        OFF_SW_BEGIN:    s_next.rdata = s_reg.mb;
        OFF_SW_SPAN:     s_next.rdata = s_reg.ms;
        OFF_VEC_LEN:     s_next.rdata = s_reg.ml;
        OFF_ACT_RATE:    s_next.rdata = s_reg.mr;
        OFF_SPACING:     s_next.rdata = s_reg.mp;
        OFF_SATURATED:   s_next.rdata = {31'h0000_0000, s_reg.sat};
        OFF_DATA_LOSS:   s_next.rdata = {31'h0000_0000, s_reg.loss};
        OFF_LINK_FAULT:  s_next.rdata = {31'h0000_0000, s_reg.fault};
        default:         s_next.rdata = RST_ZERO;
      endcase
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg       <= '0;
      s_reg.pol   <= RST_POLICY;
      s_reg.gain  <= RST_GAIN;
      s_reg.pwr   <= RST_POWER;
      s_reg.prof  <= RST_PROFILE;
      s_reg.dec   <= RST_ONE;
      s_reg.avg   <= RST_ONE;
      s_reg.fsc   <= RST_ONE;
      s_reg.tx_en <= 1'b1;
      s_reg.smax  <= 1'b1;
      s_reg.osc   <= SRCR_OSC_RUN;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state register; meas_go comes from the pacer's register.
  assign reg_rdata          = s_reg.rdata;
  assign reg_rvalid         = s_reg.rvalid;
  assign cfg_range_begin_mm = s_reg.rb;
  assign cfg_range_span_mm  = s_reg.rs;
  assign cfg_gain           = s_reg.gain;
  assign cfg_power_state    = s_reg.pwr[2:0];
  assign tx_enable          = s_reg.tx_en;
  assign cfg_profile        = s_reg.prof[2:0];
  assign cfg_decimation     = s_reg.dec;
  assign cfg_avg_count      = s_reg.avg;
  assign cfg_atten_max      = s_reg.att[0];
  assign cfg_async          = s_reg.asy[0];
  assign cfg_frame_sweeps   = s_reg.fsc;
  assign cfg_sweep_rate_mhz = s_reg.srq;
  assign sweep_rate_max     = s_reg.smax;
  assign cfg_scheme         = s_reg.sch[0];
  assign meas_go            = pace_go;
  assign osc_running        = s_reg.osc == SRCR_OSC_RUN;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Oversized gain is refused.
  a_gain_range: assert property (
    ce && reg_wr && reg_addr == OFF_GAIN && reg_wdata > GAIN_MAX |=> $stable(cfg_gain))
    else $error("out of range gain stored");
  // Power state never holds an unlisted code.
  a_power_codes: assert property (s_reg.pwr <= PWR_HIB)
    else $error("power state code illegal");
  // Profile stays in the documented span.
  a_profile_span: assert property (
    cfg_profile >= PROF_MIN[2:0] && cfg_profile <= PROF_MAX[2:0])
    else $error("profile code illegal");
  // An unlisted policy write leaves the policy alone.
  a_policy_keep: assert property (
    ce && reg_wr && reg_addr == OFF_POLICY && reg_wdata != POL_SENSOR
    && reg_wdata != POL_SOFT |=> $stable(s_reg.pol))
    else $error("illegal policy stored");
  // Transmitter off takes effect on the next edge.
  a_tx_follow: assert property (
    ce && reg_wr && reg_addr == OFF_TX_OFF |=> tx_enable == !$past(reg_wdata[0]))
    else $error("transmitter enable wrong");
  // A dropped-data event is visible on the next read.
  a_loss_read: assert property (
    ce && loss_event ##1 ce && reg_rd && reg_addr == OFF_DATA_LOSS |=> reg_rdata == RST_ONE)
    else $error("data loss not reported");
  // Saturation survives a clear in the same cycle.
  a_sat_wins: assert property (
    ce && sat_event |=> s_reg.sat)
    else $error("saturation event lost");
  // Link fault holds until the service is created again.
  a_fault_hold: assert property (
    s_reg.fault && !(ce && svc_create) |=> s_reg.fault)
    else $error("link fault dropped early");
  // Metadata takes the engine's values on new data.
  a_meta_fresh: assert property (
    ce && data_ready |=> s_reg.mb == $past(meta_begin_mm)
    && s_reg.mp == $past(meta_spacing_um))
    else $error("metadata not refreshed");
  // Zero requested rate asks for the maximum.
  a_rate_max: assert property (
    ce && reg_wr && reg_addr == OFF_REQ_RATE |=> sweep_rate_max == ($past(reg_wdata) == 0))
    else $error("maximum rate request wrong");
  // Every enabled read is answered one edge later.
  a_read_answer: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read not answered");

  c_hibernate: cover property (s_reg.osc == SRCR_OSC_HIB);
  c_measure:   cover property (meas_go);
  c_fault_rd:  cover property (reg_rvalid && s_reg.fault);

endmodule // srcr_regs

// file: srcr_regs_tb.sv
/* Self-checking bench of the sparse radar register bank.
   Assumes srcr_pkg and srcr_host_pin are compiled before it. */
`timescale 1ns/10ps
module srcr_regs_tb;
  import srcr_pkg::*;
  // Register port and engine side.
  logic        clk = 1'b0, reset_n = 1'b0, ce = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, meta_begin_mm = 32'h0, meta_span_mm = 32'h0;
  logic [31:0] meta_vec_len = 32'h0, meta_sweep_rate = 32'h0, meta_spacing_um = 32'h0;
  logic        svc_create = 1'b0, data_ready = 1'b0, meas_want = 1'b0, hib_start = 1'b0;
  logic        sat_event = 1'b0, loss_event = 1'b0, link_err_event = 1'b0;
  // Outputs of the bank and the host pin.
  logic        reg_rvalid, hib_pin, tx_enable, cfg_atten_max, cfg_async;
  logic        sweep_rate_max, cfg_scheme, meas_go, osc_running;
  logic [31:0] reg_rdata, cfg_range_begin_mm, cfg_range_span_mm, cfg_gain;
  logic [31:0] cfg_decimation, cfg_avg_count, cfg_frame_sweeps, cfg_sweep_rate_mhz;
  logic [2:0]  cfg_power_state, cfg_profile;
  int          miscompares = 0, tests_run = 0, n, i;
  // Plain configuration registers and the values written to them.
  logic [7:0]  rw_off [8] = '{OFF_RANGE_BEGIN, OFF_RANGE_SPAN, OFF_DECIM, OFF_AVG,
                              OFF_ATTEN, OFF_ASYNC, OFF_FRAME_SW, OFF_REQ_RATE};
  logic [31:0] rw_val [8] = '{32'h0000_1234, 32'h0000_0BB8, 32'h0000_0004, 32'h0000_0010,
                              32'h0000_0001, 32'h0000_0001, 32'h0000_0020, 32'h0000_2710};

  always #5 clk = ~clk;

  srcr_host_pin #(.TOGGLES(2)) u_host (.clk(clk), .start(hib_start), .pin(hib_pin));

  srcr_regs #(.HIB_TOGGLES(2)) u_dut (
    .clk(clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .svc_create(svc_create), .data_ready(data_ready),
    .meta_begin_mm(meta_begin_mm), .meta_span_mm(meta_span_mm),
    .meta_vec_len(meta_vec_len), .meta_sweep_rate(meta_sweep_rate),
    .meta_spacing_um(meta_spacing_um), .sat_event(sat_event), .loss_event(loss_event),
    .link_err_event(link_err_event), .meas_want(meas_want), .hib_pin(hib_pin),
    .cfg_range_begin_mm(cfg_range_begin_mm), .cfg_range_span_mm(cfg_range_span_mm),
    .cfg_gain(cfg_gain), .cfg_power_state(cfg_power_state), .tx_enable(tx_enable),
    .cfg_profile(cfg_profile), .cfg_decimation(cfg_decimation),
    .cfg_avg_count(cfg_avg_count), .cfg_atten_max(cfg_atten_max), .cfg_async(cfg_async),
    .cfg_frame_sweeps(cfg_frame_sweeps), .cfg_sweep_rate_mhz(cfg_sweep_rate_mhz),
    .sweep_rate_max(sweep_rate_max), .cfg_scheme(cfg_scheme), .meas_go(meas_go),
    .osc_running(osc_running));

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // One comparison; a mismatch is reported and counted at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask

  // Write strobe for one cycle; the new value is visible after the edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read strobe for one cycle; the answer stands one cycle after it.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 32'h1, 32'(reg_rvalid));
    chk("reg_rdata", e, reg_rdata);
  endtask

  // Bounded wait for a start pulse or an oscillator level; n counts edges.
  task automatic wsig(input bit osc, input logic v, input int lim);
    n = 0;
    #1;
    while ((osc ? osc_running : meas_go) !== v && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(osc ? "osc_running" : "meas_go", 32'(v), 32'(osc ? osc_running : meas_go));
  endtask

  // One-cycle pulse on an engine or host strobe.
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: data_ready <= 1'b1;
      1: svc_create <= 1'b1;
      2: meas_want <= 1'b1;
      3: hib_start <= 1'b1;
      default: {sat_event, loss_event, link_err_event} <= 3'h7;
    endcase
    @(posedge clk);
    {data_ready, svc_create, meas_want, hib_start} <= 4'h0;
    {sat_event, loss_event, link_err_event} <= 3'h0;
  endtask

  // A hang costs a mismatch and goes to the verdict.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    ce <= 1'b1;
    #1;
    chk("tx_enable", 32'h1, 32'(tx_enable));
    chk("cfg_power_state", RST_POWER, 32'(cfg_power_state));
    chk("osc_running", 32'h1, 32'(osc_running));
    rd(OFF_POLICY, RST_POLICY);
    rd(OFF_GAIN, RST_GAIN);
    rd(OFF_RATE, RST_ZERO);
    // Round trip through the plain configuration registers other than rate and transmitter off.
    for (i = 0; i < 8; i++) wr(rw_off[i], rw_val[i]);
    for (i = 0; i < 8; i++) rd(rw_off[i], rw_val[i]);
    chk("cfg_avg_count", rw_val[3], cfg_avg_count);
    chk("cfg_frame_sweeps", rw_val[6], cfg_frame_sweeps);
    chk("cfg_range_begin_mm", rw_val[0], cfg_range_begin_mm);
    chk("cfg_range_span_mm", rw_val[1], cfg_range_span_mm);
    chk("cfg_decimation", rw_val[2], cfg_decimation);
    chk("cfg_sweep_rate_mhz", rw_val[7], cfg_sweep_rate_mhz);
    chk("cfg_atten_async", 32'h3, 32'({cfg_atten_max, cfg_async}));
    chk("sweep_rate_max", 32'h0, 32'(sweep_rate_max));
    wr(OFF_REQ_RATE, RST_ZERO);
    chk("sweep_rate_max", 32'h1, 32'(sweep_rate_max));
    wr(OFF_TX_OFF, 32'h1);
    chk("tx_enable", 32'h0, 32'(tx_enable));
    // Every profile code and power codes 0 to 3, then codes just outside the lists.
    for (i = 1; i <= 5; i++) begin
      wr(OFF_PROFILE, 32'(i));
      chk("cfg_profile", 32'(i), 32'(cfg_profile));
    end
    for (i = 0; i <= 3; i++) begin
      wr(OFF_POWER, 32'(i));
      chk("cfg_power_state", 32'(i), 32'(cfg_power_state));
    end
    wr(OFF_GAIN, GAIN_MAX);
    wr(OFF_GAIN, 32'h0000_03E9);
    rd(OFF_GAIN, GAIN_MAX);
    chk("cfg_gain", GAIN_MAX, cfg_gain);
    // A write while the enable is low must not be seen.
    @(posedge clk);
    ce <= 1'b0;
    wr(OFF_GAIN, 32'h0);
    @(posedge clk);
    ce <= 1'b1;
    rd(OFF_GAIN, GAIN_MAX);
    wr(OFF_PROFILE, 32'h0000_0006);
    rd(OFF_PROFILE, PROF_MAX);
    wr(OFF_POWER, 32'h0000_0005);
    rd(OFF_POWER, PWR_ACTIVE);
    wr(OFF_SCHEME, 32'h0000_0002);
    rd(OFF_SCHEME, RST_ZERO);
    chk("cfg_scheme", 32'h0, 32'(cfg_scheme));
    wr(OFF_SCHEME, SCHEME_LAST);
    chk("cfg_scheme", 32'h1, 32'(cfg_scheme));
    rd(8'h27, RST_ZERO);
    // Metadata loads on new data; read-only places ignore writes.
    @(posedge clk);
    {meta_begin_mm, meta_span_mm, meta_vec_len} <= {32'h1000, 32'h1001, 32'h1002};
    {meta_sweep_rate, meta_spacing_um} <= {32'h1003, 32'h1004};
    pulse(0);
    for (i = 0; i < 5; i++) rd(8'h81 + 8'(i), 32'h1000 + 32'(i));
    wr(OFF_SPACING, 32'h0);
    rd(OFF_SPACING, 32'h1004);
    // Sticky flags: two clear on read, the link fault only on create.
    pulse(4);
    rd(OFF_SATURATED, 32'h1);
    rd(OFF_SATURATED, 32'h0);
    rd(OFF_DATA_LOSS, 32'h1);
    rd(OFF_DATA_LOSS, 32'h0);
    rd(OFF_LINK_FAULT, 32'h1);
    rd(OFF_LINK_FAULT, 32'h1);
    pulse(1);
    rd(OFF_LINK_FAULT, 32'h0);
    // Sensor pacing: 1e11 counts at 0xFFFFFFFF per cycle gives 23 or 24.
    wr(OFF_RATE, 32'hFFFF_FFFF);
    wr(OFF_POLICY, 32'h0000_0003);
    rd(OFF_POLICY, RST_POLICY);
    wr(OFF_POLICY, POL_SENSOR);
    wsig(1'b0, 1'b1, 60);
    @(posedge clk);
    wsig(1'b0, 1'b1, 60);
    chk("pace_gap_ok", 32'h1, 32'(n == 22 || n == 23));
    // Software cap with rate zero: quiet until asked, then prompt.
    wr(OFF_RATE, RST_ZERO);
    wr(OFF_POLICY, POL_SOFT);
    repeat (30) @(posedge clk);
    wsig(1'b0, 1'b0, 1);
    pulse(2);
    wsig(1'b0, 1'b1, 3);
    // Hibernate entered and left by host pin toggles.
    wr(OFF_POWER, PWR_HIB);
    pulse(3);
    wsig(1'b1, 1'b0, 50);
    pulse(3);
    wsig(1'b1, 1'b1, 50);
    complete_run();
  end
endmodule // srcr_regs_tb
